// ### bench/dpg_board.sv
`timescale 1ns/10ps
module dpg_board #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic [W-1:0] drv_i,
    input  wire logic [W-1:0] oe_i,
    input  wire logic [W-1:0] pu_i,
    input  wire logic [W-1:0] ext_i,
    input  wire logic [W-1:0] ext_en_i,
    output logic      [W-1:0] pin_o
);
    // Floating pins show the inverse of their last level, so a stale value never reads as good
    logic [W-1:0] float_reg = '0;
    wire  [W-1:0] ext_sel   = ~oe_i & ext_en_i;
    wire  [W-1:0] free_sel  = ~oe_i & ~ext_en_i;
    always_ff @(posedge clk_i) begin
        float_reg <= ~pin_o;
    end
    assign pin_o = (oe_i & drv_i) | (ext_sel & ext_i) | (free_sel & pu_i) | (free_sel & ~pu_i & float_reg);
endmodule

// ### bench/dpg_gpio_sva.sv
`timescale 1ns/10ps
module dpg_gpio_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic [7:0]  wide_port_pin_n_oe_o,
    input wire logic [7:0]  wide_port_pullup_o,
    input wire logic [7:0]  wide_periph_own_i,
    input wire logic [7:0]  wide_periph_oe_i,
    input wire logic [1:0]  narrow_port_pin_n_i,
    input wire logic [1:0]  narrow_port_pin_n_o,
    input wire logic [1:0]  narrow_port_pin_n_oe_o,
    input wire logic        serial_tx_i,
    input wire logic        serial_rx_o,
    input wire logic        serial_interface_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
    sequence s_ans; wb_ack_o || wb_err_o; endsequence
    sequence s_rx_steady; (serial_interface_enable_o && $stable(narrow_port_pin_n_i[1])) [*4]; endsequence
    wire narrow_rd = wb_ack_o && !wb_we_i
        && (wb_adr_i == dpg_pkg::NARROW_DIR_ADDR || wb_adr_i == dpg_pkg::NARROW_LATCH_ADDR);
    wire ser_on    = serial_interface_enable_o;
    a_bus_answer: assert property (s_req |=> s_ans)
        else $error("no answer one cycle after a request");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wide_port_pin_n_oe_o
        && !narrow_port_pin_n_oe_o && !wide_port_pullup_o && !ser_on) else $error("outputs not quiet after reset");
    a_narrow_upper: assert property (narrow_rd |-> wb_dat_o[31:2] == 30'h0)
        else $error("narrow register upper bits not zero");
    a_pullup_input: assert property ((wide_port_pullup_o & wide_port_pin_n_oe_o
        & ~$past(wide_periph_own_i)) == 8'h00) else $error("pullup active on an output pin");
    a_periph_dir: assert property (!$past(rst_i) |-> ((wide_port_pin_n_oe_o ^ $past(wide_periph_oe_i))
        & $past(wide_periph_own_i)) == 8'h00) else $error("owned pin direction not from peripheral");
    a_dir_by_write: assert property (!$past(rst_i) && !wide_periph_own_i && !$past(wide_periph_own_i)
        && !$past(wide_periph_own_i, 2) && $changed(wide_port_pin_n_oe_o) |-> $past(wb_ack_o) && $past(wb_we_i)
        && $past(wb_adr_i) == dpg_pkg::WIDE_DIR_ADDR) else $error("wide drive changed without direction write");
    a_tx_drive: assert property (ser_on && $past(ser_on) |-> narrow_port_pin_n_oe_o == 2'h1
        && narrow_port_pin_n_o[0] == $past(serial_tx_i)) else $error("narrow pin 0 not driven by transmitter");
    a_rx_idle: assert property (!ser_on && !$past(ser_on) |-> serial_rx_o)
        else $error("receiver input not idle while disabled");
    a_rx_follow: assert property (s_rx_steady |-> serial_rx_o == narrow_port_pin_n_i[1])
        else $error("receiver input does not follow narrow pin 1");
endmodule
bind dpg_gpio dpg_gpio_sva dpg_gpio_sva_inst (.*);

// ### bench/dual_port_gpio_with_pullups_test.sv
`timescale 1ns/10ps
module dual_port_gpio_with_pullups_test;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic        wb_ack_o, wb_err_o, bus_err, serial_tx_i = 1'b0, serial_rx_o, serial_interface_enable_o;
    logic [7:0]  wide_port_pin_n_i, wide_port_pin_n_o, wide_port_pin_n_oe_o, wide_port_pullup_o;
    logic [7:0]  wide_periph_own_i = 8'h00, wide_periph_out_i = 8'h00, wide_periph_oe_i = 8'h00;
    logic [7:0]  w_ext = 8'h00, w_en = 8'h00;
    logic [1:0]  narrow_port_pin_n_i, narrow_port_pin_n_o, narrow_port_pin_n_oe_o, n_ext = 2'h0, n_en = 2'h0;
    int          error_cnt = 0, total_checks = 0, cycles = 0;
    dpg_gpio dpg_gpio_inst (.*);
    dpg_board #(.W(8)) dpg_board_inst (.clk_i(clk_i), .drv_i(wide_port_pin_n_o), .oe_i(wide_port_pin_n_oe_o),
        .pu_i(wide_port_pullup_o), .ext_i(w_ext), .ext_en_i(w_en), .pin_o(wide_port_pin_n_i));
    dpg_board #(.W(2)) dpg_board_n_inst (.clk_i(clk_i), .drv_i(narrow_port_pin_n_o), .oe_i(narrow_port_pin_n_oe_o),
        .pu_i(2'h0), .ext_i(n_ext), .ext_en_i(n_en), .pin_o(narrow_port_pin_n_i));
    initial forever #2 clk_i = ~clk_i;
    task finish_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            finish_test;
        end
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Holds the request until ack or err is sampled, then releases it
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        q = wb_dat_o;
        bus_err = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task settle;
        repeat (4) @(posedge clk_i);
    endtask
    task t_reset;
        check({24'h0, wide_port_pin_n_oe_o}, 32'h0);
        wb(1'b0, dpg_pkg::WIDE_DIR_ADDR, 32'h0);
        check(q, 32'h0);
        wb(1'b0, dpg_pkg::NARROW_DIR_ADDR, 32'h0);
        check(q, 32'h0);
        wb(1'b0, 8'hFC, 32'h0);
        check({31'h0, bus_err}, 32'h1);
    endtask
    task t_wide;
        w_en  <= 8'hF0;
        w_ext <= 8'h3C;
        wb(1'b1, dpg_pkg::WIDE_LATCH_ADDR, 32'hA5);
        wb(1'b1, dpg_pkg::WIDE_DIR_ADDR, 32'h0F);
        settle;
        check({24'h0, wide_port_pin_n_oe_o}, 32'h0F);
        check({28'h0, wide_port_pin_n_o[3:0]}, 32'h5);
        wb(1'b0, dpg_pkg::WIDE_LATCH_ADDR, 32'h0);
        check(q, 32'h35);
        wb(1'b1, dpg_pkg::WIDE_DIR_ADDR, 32'hFF);
        wb(1'b0, dpg_pkg::WIDE_LATCH_ADDR, 32'h0);
        check(q, 32'hA5);
        wb(1'b1, dpg_pkg::WIDE_DIR_ADDR, 32'h0F);
        wb(1'b0, dpg_pkg::WIDE_DIR_ADDR, 32'h0);
        check(q, 32'h0F);
    endtask
    task t_pullup;
        wb(1'b1, dpg_pkg::WIDE_PULLUP_ADDR, 32'hFF);
        settle;
        check({24'h0, wide_port_pullup_o}, 32'hF0);
        wb(1'b1, dpg_pkg::WIDE_PULLUP_ADDR, 32'h81);
        settle;
        check({24'h0, wide_port_pullup_o}, 32'h80);
        wb(1'b0, dpg_pkg::WIDE_PULLUP_ADDR, 32'h0);
        check(q, 32'h81);
    endtask
    task t_narrow;
        wb(1'b1, dpg_pkg::NARROW_LATCH_ADDR, 32'hFE);
        wb(1'b1, dpg_pkg::NARROW_DIR_ADDR, 32'hFF);
        wb(1'b0, dpg_pkg::NARROW_DIR_ADDR, 32'h0);
        check(q, 32'h3);
        wb(1'b0, dpg_pkg::NARROW_LATCH_ADDR, 32'h0);
        check(q, 32'h2);
        settle;
        check({28'h0, narrow_port_pin_n_oe_o, narrow_port_pin_n_o}, 32'hE);
        n_en <= 2'h2;
        wb(1'b1, dpg_pkg::NARROW_DIR_ADDR, 32'h1);
        settle;
        wb(1'b0, dpg_pkg::NARROW_LATCH_ADDR, 32'h0);
        check(q, 32'h0);
    endtask
    task t_serial;
        n_ext <= 2'h2;
        serial_tx_i <= 1'b1;
        wb(1'b1, dpg_pkg::NARROW_DIR_ADDR, 32'h3);
        wb(1'b1, dpg_pkg::PERIPH_CTRL_ADDR, 32'h1);
        settle;
        check({29'h0, narrow_port_pin_n_oe_o, narrow_port_pin_n_o[0]}, 32'h3);
        check({31'h0, serial_rx_o}, 32'h1);
        check({31'h0, serial_interface_enable_o}, 32'h1);
        wb(1'b0, dpg_pkg::PERIPH_CTRL_ADDR, 32'h0);
        check(q, 32'h1);
        n_ext <= 2'h0;
        serial_tx_i <= 1'b0;
        settle;
        check({30'h0, narrow_port_pin_n_o[0], serial_rx_o}, 32'h0);
        wb(1'b0, dpg_pkg::NARROW_LATCH_ADDR, 32'h0);
        check(q, 32'h2);
        wb(1'b1, dpg_pkg::PERIPH_CTRL_ADDR, 32'h0);
        settle;
        check({28'h0, narrow_port_pin_n_oe_o, serial_rx_o, serial_interface_enable_o}, 32'hE);
    endtask
    task t_periph;
        wide_periph_own_i <= 8'h03;
        wide_periph_oe_i  <= 8'h01;
        wide_periph_out_i <= 8'h02;
        settle;
        check({24'h0, wide_port_pin_n_oe_o}, 32'h0D);
        check({30'h0, wide_port_pin_n_o[1:0]}, 32'h2);
        wb(1'b0, dpg_pkg::WIDE_LATCH_ADDR, 32'h0);
        check(q, 32'h35);
        wide_periph_own_i <= 8'h00;
        settle;
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_wide;
        t_pullup;
        t_narrow;
        t_serial;
        t_periph;
        finish_test;
    end
endmodule

// ### design/dpg_gpio.sv
// Functional notes
// - Reset clears all eight wide-port direction bits so every wide pin starts as an input.
// - A wide-port direction bit of 1 enables its pin's output buffer and 0 disables it.
// - Reading the wide latch address returns the latch for output pins and the sampled pin for input pins.
// - Writes to either data latch always store, whatever the direction, without touching sampled input.
// - A wide-port pullup is on only while its enable bit is 1 and its direction bit is 0.
// - Each of the eight wide pins has its own writable pullup enable bit, 1 connects and 0 disconnects.
// - The narrow port has two pins, each with a read/write latch and its own direction bit.
// - While the serial interface owns the narrow pins, direction bits do not set drive but still steer reads.
// - With the serial enable set, narrow pin 1 feeds the serial receiver; otherwise it is plain I/O.
// - With the serial enable set, narrow pin 0 is driven by the serial transmitter; otherwise plain I/O.
// - Reset clears both narrow direction bits, and a direction bit of 1 means output, 0 input.
// - Reading the narrow latch address returns latch bits for outputs and sampled pins for inputs.
// - Wide pins claimed by the synchronous serial or timer peripherals take direction from the peripheral.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
module dpg_gpio #(
    parameter int WIDE_W   = dpg_pkg::WIDE_WIDTH,
    parameter int NARROW_W = dpg_pkg::NARROW_WIDTH
) (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    // Classic Wishbone slave
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [dpg_pkg::ADDR_WIDTH-1:0] wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output logic      [31:0]                  wb_dat_o,
    output logic                              wb_ack_o,
    output logic                              wb_err_o,
    // Wide port pins
    input  wire logic [WIDE_W-1:0]            wide_port_pin_n_i,
    output logic      [WIDE_W-1:0]            wide_port_pin_n_o,
    output logic      [WIDE_W-1:0]            wide_port_pin_n_oe_o,
    output logic      [WIDE_W-1:0]            wide_port_pullup_o,
    // Peripheral takeover of wide pins
    input  wire logic [WIDE_W-1:0]            wide_periph_own_i,
    input  wire logic [WIDE_W-1:0]            wide_periph_out_i,
    input  wire logic [WIDE_W-1:0]            wide_periph_oe_i,
    // Narrow port pins
    input  wire logic [NARROW_W-1:0]          narrow_port_pin_n_i,
    output logic      [NARROW_W-1:0]          narrow_port_pin_n_o,
    output logic      [NARROW_W-1:0]          narrow_port_pin_n_oe_o,
    // Serial interface hookup
    input  wire logic                         serial_tx_i,
    output logic                              serial_rx_o,
    output logic                              serial_interface_enable_o
);
    initial begin
        if (WIDE_W != dpg_pkg::WIDE_WIDTH || NARROW_W != dpg_pkg::NARROW_WIDTH) begin
            $error("dpg_gpio: port widths are fixed at 8 and 2");
        end
    end

    // Register state
    logic [WIDE_W-1:0]   wide_port_latch_reg;
    logic [WIDE_W-1:0]   wide_port_direction_reg;
    logic [WIDE_W-1:0]   wide_port_pullup_enables_reg;
    logic [NARROW_W-1:0] narrow_port_latch_reg;
    logic [NARROW_W-1:0] narrow_port_direction_reg;
    logic                serial_interface_enable_reg;
    logic [31:0]         rd_data_reg;
    logic                ack_reg;
    logic                err_reg;

    // Output flops
    logic [WIDE_W-1:0]   wide_out_reg;
    logic [WIDE_W-1:0]   wide_oe_reg;
    logic [WIDE_W-1:0]   wide_pu_reg;
    logic [NARROW_W-1:0] narrow_out_reg;
    logic [NARROW_W-1:0] narrow_oe_reg;
    logic                serial_rx_reg;

    // Synchronised pin levels
    logic [WIDE_W-1:0]   wide_pin_sync;
    logic [NARROW_W-1:0] narrow_pin_sync;
    logic [WIDE_W+NARROW_W-1:0] all_pins_sync;

    dpg_pin_sync #(
        .WIDTH (WIDE_W + NARROW_W)
    ) dpg_pin_sync_inst (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({narrow_port_pin_n_i, wide_port_pin_n_i}),
        .sync_o  (all_pins_sync)
    );

    assign wide_pin_sync   = all_pins_sync[WIDE_W-1:0];
    assign narrow_pin_sync = all_pins_sync[WIDE_W+NARROW_W-1:WIDE_W];

    // Per-bit select: latch where the direction bit is 1, pin where 0
    function automatic logic [7:0] read_mux(input logic [7:0] dir, input logic [7:0] latch,
                                            input logic [7:0] pin);
        read_mux = (dir & latch) | (~dir & pin);
    endfunction

    // Apply a byte-lane-0 write to an 8-bit field
    function automatic logic [7:0] lane0_write(input logic [7:0] old_val, input logic [31:0] data,
                                               input logic [3:0] sel);
        lane0_write = sel[0] ? data[7:0] : old_val;
    endfunction

    // Bus decode
    wire bus_req      = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
    wire bus_wr       = bus_req & wb_we_i;
    wire hit_wlatch   = wb_adr_i == dpg_pkg::WIDE_LATCH_ADDR;
    wire hit_nlatch   = wb_adr_i == dpg_pkg::NARROW_LATCH_ADDR;
    wire hit_wdir     = wb_adr_i == dpg_pkg::WIDE_DIR_ADDR;
    wire hit_wpu      = wb_adr_i == dpg_pkg::WIDE_PULLUP_ADDR;
    wire hit_ndir     = wb_adr_i == dpg_pkg::NARROW_DIR_ADDR;
    wire hit_ctrl     = wb_adr_i == dpg_pkg::PERIPH_CTRL_ADDR;
    wire hit_any      = hit_wlatch | hit_nlatch | hit_wdir | hit_wpu | hit_ndir | hit_ctrl;

    // Zero-extended narrow fields so the mux function serves both ports
    wire [7:0] n_dir8   = {6'h00, narrow_port_direction_reg};
    wire [7:0] n_latch8 = {6'h00, narrow_port_latch_reg};
    wire [7:0] n_pin8   = {6'h00, narrow_pin_sync};

    wire [7:0] wide_rd   = read_mux(wide_port_direction_reg, wide_port_latch_reg, wide_pin_sync);
    wire [7:0] narrow_rd = read_mux(n_dir8, n_latch8, n_pin8);

    wire [7:0] rd_byte =
        hit_wlatch ? wide_rd :
        hit_nlatch ? narrow_rd :
        hit_wdir   ? wide_port_direction_reg :
        hit_wpu    ? wide_port_pullup_enables_reg :
        hit_ndir   ? n_dir8 :
        hit_ctrl   ? {7'h00, serial_interface_enable_reg} :
                     8'h00;

    // Next-state values
    wire [7:0] wlatch_wdata = lane0_write(wide_port_latch_reg, wb_dat_i, wb_sel_i);
    wire [7:0] nlatch_wdata = lane0_write(n_latch8, wb_dat_i, wb_sel_i);
    wire [7:0] wdir_wdata   = lane0_write(wide_port_direction_reg, wb_dat_i, wb_sel_i);
    wire [7:0] wpu_wdata    = lane0_write(wide_port_pullup_enables_reg, wb_dat_i, wb_sel_i);
    wire [7:0] ndir_wdata   = lane0_write(n_dir8, wb_dat_i, wb_sel_i);
    wire [7:0] ctrl_wdata   = lane0_write({7'h00, serial_interface_enable_reg}, wb_dat_i, wb_sel_i);

    // Pin drive
    wire [WIDE_W-1:0] wide_oe_next  = (wide_periph_own_i & wide_periph_oe_i) |
                                      (~wide_periph_own_i & wide_port_direction_reg);
    wire [WIDE_W-1:0] wide_out_next = (wide_periph_own_i & wide_periph_out_i) |
                                      (~wide_periph_own_i & wide_port_latch_reg);
    // Pullup follows the enables and the GPIO direction, dropping as soon as a pin's direction bit turns output
    wire [WIDE_W-1:0] wide_pu_next  = wide_port_pullup_enables_reg & ~wide_port_direction_reg;

    // Serial ownership: transmitter drives pin 0, pin 1 is an input to the receiver
    wire [NARROW_W-1:0] narrow_oe_next  = serial_interface_enable_reg ?
                                          NARROW_W'(1 << dpg_pkg::NARROW_TX_PIN) :
                                          narrow_port_direction_reg;
    wire [NARROW_W-1:0] narrow_out_next = serial_interface_enable_reg ?
                                          NARROW_W'({1'b0, serial_tx_i}) :
                                          narrow_port_latch_reg;
    // Receiver idles high while the interface does not own the pin
    wire serial_rx_next = serial_interface_enable_reg ?
                          narrow_pin_sync[dpg_pkg::NARROW_RX_PIN] : 1'b1;

    // Per-register write strobes; an unmapped address raises none of them
    wire wr_wlatch = bus_wr & hit_wlatch;
    wire wr_nlatch = bus_wr & hit_nlatch;
    wire wr_wdir   = bus_wr & hit_wdir;
    wire wr_wpu    = bus_wr & hit_wpu;
    wire wr_ndir   = bus_wr & hit_ndir;
    wire wr_ctrl   = bus_wr & hit_ctrl;

    // Latches store every write, whatever the direction bits say
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wide_port_latch_reg <= dpg_pkg::WIDE_LATCH_RST;
        end else if (wr_wlatch) begin
            wide_port_latch_reg <= wlatch_wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            narrow_port_latch_reg <= dpg_pkg::NARROW_LATCH_RST;
        end else if (wr_nlatch) begin
            narrow_port_latch_reg <= nlatch_wdata[NARROW_W-1:0];
        end
    end

    // Direction bits clear on reset so no pin drives before software or an owning peripheral asks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wide_port_direction_reg <= dpg_pkg::WIDE_DIR_RST;
        end else if (wr_wdir) begin
            wide_port_direction_reg <= wdir_wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wide_port_pullup_enables_reg <= dpg_pkg::WIDE_PULLUP_RST;
        end else if (wr_wpu) begin
            wide_port_pullup_enables_reg <= wpu_wdata;
        end
    end

    // Upper bits of the write are dropped here, so they always read back as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            narrow_port_direction_reg <= dpg_pkg::NARROW_DIR_RST;
        end else if (wr_ndir) begin
            narrow_port_direction_reg <= ndir_wdata[NARROW_W-1:0];
        end
    end

    // Serial enable hands the narrow pins to the serial interface
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_interface_enable_reg <= dpg_pkg::SERIAL_EN_RST;
        end else if (wr_ctrl) begin
            serial_interface_enable_reg <= ctrl_wdata[dpg_pkg::SERIAL_EN_BIT];
        end
    end

    // Bus answer: one wait state, ack or err for one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req & hit_any;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_reg <= 1'b0;
        end else begin
            err_reg <= bus_req & ~hit_any;
        end
    end

    // Read data is zero outside a read answer, so no stale byte lingers on the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_reg <= 32'h00000000;
        end else begin
            rd_data_reg <= (bus_req & ~wb_we_i) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // Pin output flops: pads change one edge after the register that steers them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wide_out_reg <= '0;
        end else begin
            wide_out_reg <= wide_out_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wide_oe_reg <= '0;
        end else begin
            wide_oe_reg <= wide_oe_next;
        end
    end

    // Pullup and drive enable update on the same edge, so they never overlap on pins no peripheral owns
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wide_pu_reg <= '0;
        end else begin
            wide_pu_reg <= wide_pu_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            narrow_out_reg <= '0;
        end else begin
            narrow_out_reg <= narrow_out_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            narrow_oe_reg <= '0;
        end else begin
            narrow_oe_reg <= narrow_oe_next;
        end
    end

    // Receiver input rests at the idle level so a disabled receiver sees no start bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_rx_reg <= 1'b1;
        end else begin
            serial_rx_reg <= serial_rx_next;
        end
    end

    assign wb_dat_o                  = rd_data_reg;
    assign wb_ack_o                  = ack_reg;
    assign wb_err_o                  = err_reg;
    assign wide_port_pin_n_o         = wide_out_reg;
    assign wide_port_pin_n_oe_o      = wide_oe_reg;
    assign wide_port_pullup_o        = wide_pu_reg;
    assign narrow_port_pin_n_o       = narrow_out_reg;
    assign narrow_port_pin_n_oe_o    = narrow_oe_reg;
    assign serial_rx_o               = serial_rx_reg;
    assign serial_interface_enable_o = serial_interface_enable_reg;
endmodule

// ### design/dpg_pin_sync.sv
`timescale 1ns/10ps
module dpg_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    initial begin
        if (WIDTH < 1) begin
            $error("dpg_pin_sync: WIDTH must be at least 1");
        end
    end

    // Two stages; only the second stage is visible outside
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule

// ### pkg/dpg_pkg.sv
package dpg_pkg;
    localparam int WIDE_WIDTH   = 8;
    localparam int NARROW_WIDTH = 2;
    localparam int ADDR_WIDTH   = 8;

    // Register byte addresses (word indices times four)
    localparam logic [7:0] WIDE_LATCH_IDX    = 8'h03;
    localparam logic [7:0] NARROW_LATCH_IDX  = 8'h08;
    localparam logic [7:0] WIDE_DIR_IDX      = 8'h07;
    localparam logic [7:0] WIDE_PULLUP_IDX   = 8'h0C;
    localparam logic [7:0] NARROW_DIR_IDX    = 8'h0B;
    localparam logic [7:0] PERIPH_CTRL_IDX   = 8'h10;

    localparam logic [ADDR_WIDTH-1:0] WIDE_LATCH_ADDR   = ADDR_WIDTH'({WIDE_LATCH_IDX, 2'b00});
    localparam logic [ADDR_WIDTH-1:0] NARROW_LATCH_ADDR = ADDR_WIDTH'({NARROW_LATCH_IDX, 2'b00});
    localparam logic [ADDR_WIDTH-1:0] WIDE_DIR_ADDR     = ADDR_WIDTH'({WIDE_DIR_IDX, 2'b00});
    localparam logic [ADDR_WIDTH-1:0] WIDE_PULLUP_ADDR  = ADDR_WIDTH'({WIDE_PULLUP_IDX, 2'b00});
    localparam logic [ADDR_WIDTH-1:0] NARROW_DIR_ADDR   = ADDR_WIDTH'({NARROW_DIR_IDX, 2'b00});
    localparam logic [ADDR_WIDTH-1:0] PERIPH_CTRL_ADDR  = ADDR_WIDTH'({PERIPH_CTRL_IDX, 2'b00});

    // Peripheral control fields
    localparam int SERIAL_EN_BIT = 0;

    // Reset values
    localparam logic [7:0] WIDE_DIR_RST    = 8'h00;
    localparam logic [7:0] WIDE_PULLUP_RST = 8'h00;
    localparam logic [1:0] NARROW_DIR_RST  = 2'h0;
    localparam logic [7:0] WIDE_LATCH_RST  = 8'h00;
    localparam logic [1:0] NARROW_LATCH_RST = 2'h0;
    localparam logic       SERIAL_EN_RST   = 1'b0;

    // Narrow port pin roles
    localparam int NARROW_TX_PIN = 0;
    localparam int NARROW_RX_PIN = 1;
endpackage
